// >>> rtl/egpio_port.sv
// Purpose: register-controlled 8-bit general-purpose port, top level
// Assumes: pad_in is asynchronous, bus strobes are one cycle and exclusive
// Notes: read data appear the cycle after the read strobe, zero otherwise
//
// Contract
// - an output-mode pin drives its stored pin-level bit in push-pull, one level in open-drain, none in float.
// - written pin-level value reads back unchanged in output mode.
// - an input-mode pin reads back its present pin level.
// - pin-level bit n belongs to pin n, bit 7 highest.
// - level bit 0 means low, 1 means high, for output and input.
// - direction bit n: 0 makes pin n output, 1 input.
// - direction register holds eight read-write bits, 7 down to 0.
// - direction clears to zero at reset, all pins outputs.
// - pin-level register is 8-bit read-write, clears to zero at reset.
// - low and high drive-select bit n form pin n's two-bit code.
// - drive code meaning depends on the pin's direction bit.
// - low drive-select accepts byte and word access; word covers high too.
// - high drive-select is 8-bit read-write, zero at reset; pins float.
// - output codes: 00 float, 01 p-open-drain, 10 n-open-drain, 11 push-pull.
// - input codes: 00 float, 01 pull-down, 10 pull-up, 11 float.
`timescale 1ns/10ps
`default_nettype none
module egpio_port #(
   parameter int PINS = egpio_pkg::PIN_COUNT
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [egpio_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [egpio_pkg::DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_word,
   output logic [egpio_pkg::DATA_W-1:0] bus_rdata,
   input wire logic [PINS-1:0] pad_in,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe,
   output logic [PINS-1:0] pad_pull_up,
   output logic [PINS-1:0] pad_pull_down
);
   egpio_pad_if #(.PINS(PINS)) pads ();

   // configuration registers
   logic [PINS-1:0] pin_level_q;
   logic [PINS-1:0] pin_level_d;
   logic [PINS-1:0] pin_direction_q;
   logic [PINS-1:0] pin_direction_d;
   logic [PINS-1:0] drive_select_low_q;
   logic [PINS-1:0] drive_select_low_d;
   logic [PINS-1:0] drive_select_high_q;
   logic [PINS-1:0] drive_select_high_d;
   logic [egpio_pkg::DATA_W-1:0] rdata_q;
   logic [egpio_pkg::DATA_W-1:0] rdata_d;

   // address decode
   wire logic hit_level;
   wire logic hit_direction;
   wire logic hit_drive_low;
   wire logic hit_drive_high;
   wire logic hit_oe_state;
   wire logic hit_pu_state;
   wire logic hit_pd_state;
   wire logic word_drive;
   wire logic wr_level;
   wire logic wr_direction;
   wire logic wr_drive_low;
   wire logic wr_drive_high;

   // byte lanes and read views
   wire logic [PINS-1:0] low_lane;
   wire logic [PINS-1:0] high_lane;
   wire logic [PINS-1:0] pin_sync;
   wire logic [PINS-1:0] level_view;
   wire logic [PINS-1:0] byte_view;
   wire logic [egpio_pkg::DATA_W-1:0] read_word;
   wire logic any_hit;

   assign hit_level = (bus_addr == egpio_pkg::ADDR_PIN_LEVEL);
   assign hit_direction = (bus_addr == egpio_pkg::ADDR_PIN_DIRECTION);
   assign hit_drive_low = (bus_addr == egpio_pkg::ADDR_DRIVE_SELECT_LOW);
   assign hit_drive_high = (bus_addr == egpio_pkg::ADDR_DRIVE_SELECT_HIGH);
   assign hit_oe_state = (bus_addr == egpio_pkg::ADDR_PAD_ENABLE_STATE);
   assign hit_pu_state = (bus_addr == egpio_pkg::ADDR_PAD_PULL_UP_STATE);
   assign hit_pd_state = (bus_addr == egpio_pkg::ADDR_PAD_PULL_DOWN_STATE);
   assign any_hit = hit_level || hit_direction || hit_drive_low || hit_drive_high ||
                    hit_oe_state || hit_pu_state || hit_pd_state;

   // only the low drive-select address takes a word; elsewhere a word acts as a byte
   assign word_drive = bus_word && hit_drive_low;

   assign low_lane = bus_wdata[PINS-1:0];
   assign high_lane = bus_wdata[egpio_pkg::BYTE_W+PINS-1:egpio_pkg::BYTE_W];

   assign wr_level = bus_wr && hit_level;
   assign wr_direction = bus_wr && hit_direction;
   assign wr_drive_low = bus_wr && hit_drive_low;
   assign wr_drive_high = bus_wr && (hit_drive_high || word_drive);

   // stored level updates regardless of direction, so it is ready when the pin turns output
   assign pin_level_d = wr_level ? low_lane : pin_level_q;
   assign pin_direction_d = wr_direction ? low_lane : pin_direction_q;
   assign drive_select_low_d = wr_drive_low ? low_lane : drive_select_low_q;
   assign drive_select_high_d = !wr_drive_high ? drive_select_high_q :
                                word_drive ? high_lane : low_lane;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_level_q <= egpio_pkg::RST_PIN_LEVEL[PINS-1:0];
         pin_direction_q <= egpio_pkg::RST_PIN_DIRECTION[PINS-1:0];
         drive_select_low_q <= egpio_pkg::RST_DRIVE_SELECT_LOW[PINS-1:0];
         drive_select_high_q <= egpio_pkg::RST_DRIVE_SELECT_HIGH[PINS-1:0];
      end else begin
         pin_level_q <= pin_level_d;
         pin_direction_q <= pin_direction_d;
         drive_select_low_q <= drive_select_low_d;
         drive_select_high_q <= drive_select_high_d;
      end
   end

   // metastability guard: the pins are not tied to this clock
   egpio_sync #(.WIDTH(PINS)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(pad_in),
      .sync_out(pin_sync)
   );

   // per-bit view: input pins show the pin, output pins show the stored bit
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_view
         assign level_view[gi] = (pin_direction_q[gi] == egpio_pkg::DIR_INPUT) ?
                                 pin_sync[gi] : pin_level_q[gi];
      end
   endgenerate

   assign byte_view = hit_level ? level_view :
                      hit_direction ? pin_direction_q :
                      hit_drive_low ? drive_select_low_q :
                      hit_drive_high ? drive_select_high_q :
                      hit_oe_state ? pads.pad_oe :
                      hit_pu_state ? pads.pull_up :
                      hit_pd_state ? pads.pull_down :
                      '0;

   // unmapped addresses read zero
   assign read_word = !any_hit ? egpio_pkg::WORD_ZERO :
                      word_drive ? {{(egpio_pkg::BYTE_W-PINS){1'b0}}, drive_select_high_q,
                                    {(egpio_pkg::BYTE_W-PINS){1'b0}}, drive_select_low_q} :
                      {egpio_pkg::BYTE_ZERO, {(egpio_pkg::BYTE_W-PINS){1'b0}}, byte_view};

   assign rdata_d = bus_rd ? read_word : egpio_pkg::WORD_ZERO;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= egpio_pkg::WORD_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign pads.level = pin_level_q;
   assign pads.dir = pin_direction_q;
   assign pads.code_lo = drive_select_low_q;
   assign pads.code_hi = drive_select_high_q;

   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pad
         egpio_pad_cell #(.PIN(gi)) u_cell (
            .clk(clk),
            .sys_rst(sys_rst),
            .pads(pads.pad)
         );
      end
   endgenerate

   // pad controls are flops inside the cells
   assign pad_out = pads.pad_out;
   assign pad_oe = pads.pad_oe;
   assign pad_pull_up = pads.pull_up;
   assign pad_pull_down = pads.pull_down;
   assign bus_rdata = rdata_q;
endmodule
`default_nettype wire

// >>> rtl/egpio_pkg.sv
// Purpose: constants and types shared by the 8-bit general-purpose port
// Assumes: byte-addressed register port, 50 MHz system clock
// Notes: drive codes are {high select bit, low select bit}
package egpio_pkg;
   localparam int PIN_COUNT = 8;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int SYNC_STAGES = 2;
   localparam int CLK_PERIOD_NS = 20;

   localparam logic [15:0] ADDR_PIN_LEVEL = 16'hF252;
   localparam logic [15:0] ADDR_PIN_DIRECTION = 16'hF253;
   localparam logic [15:0] ADDR_DRIVE_SELECT_LOW = 16'hF254;
   localparam logic [15:0] ADDR_DRIVE_SELECT_HIGH = 16'hF255;
   localparam logic [15:0] ADDR_PAD_ENABLE_STATE = 16'hF25A;
   localparam logic [15:0] ADDR_PAD_PULL_UP_STATE = 16'hF25B;
   localparam logic [15:0] ADDR_PAD_PULL_DOWN_STATE = 16'hF25C;

   localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
   localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
   localparam logic [7:0] RST_DRIVE_SELECT_LOW = 8'h00;
   localparam logic [7:0] RST_DRIVE_SELECT_HIGH = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   localparam logic DIR_OUTPUT = 1'b0;
   localparam logic DIR_INPUT = 1'b1;
   localparam logic LEVEL_LOW = 1'b0;
   localparam logic LEVEL_HIGH = 1'b1;

   // output mode codes
   localparam logic [1:0] DRV_HIZ = 2'h0;
   localparam logic [1:0] DRV_PCH_OPEN = 2'h1;
   localparam logic [1:0] DRV_NCH_OPEN = 2'h2;
   localparam logic [1:0] DRV_PUSH_PULL = 2'h3;
   // input mode codes
   localparam logic [1:0] IN_HIZ = 2'h0;
   localparam logic [1:0] IN_PULL_DOWN = 2'h1;
   localparam logic [1:0] IN_PULL_UP = 2'h2;
   localparam logic [1:0] IN_HIZ_ALT = 2'h3;

   typedef logic [BYTE_W-1:0] egpio_byte_t;
endpackage

// >>> rtl/egpio_pad_if.sv
// Purpose: carries per-pin configuration to the pad cells and pad state back
// Assumes: one bit per pin in every vector
// Notes: regs side owns configuration, pad side owns pad controls
`timescale 1ns/10ps
`default_nettype none
interface egpio_pad_if #(
   parameter int PINS = 8
);
   logic [PINS-1:0] level;
   logic [PINS-1:0] dir;
   logic [PINS-1:0] code_lo;
   logic [PINS-1:0] code_hi;
   logic [PINS-1:0] pad_out;
   logic [PINS-1:0] pad_oe;
   logic [PINS-1:0] pull_up;
   logic [PINS-1:0] pull_down;

   modport regs (
      output level,
      output dir,
      output code_lo,
      output code_hi,
      input pad_out,
      input pad_oe,
      input pull_up,
      input pull_down
   );

   modport pad (
      input level,
      input dir,
      input code_lo,
      input code_hi,
      output pad_out,
      output pad_oe,
      output pull_up,
      output pull_down
   );
endinterface
`default_nettype wire

// >>> rtl/egpio_sync.sv
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module egpio_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> rtl/egpio_pad_cell.sv
// Purpose: turns one pin's level, direction and drive code into pad controls
// Assumes: pad controls are registered, so they follow config by one clock
// Notes: open-drain modes drive only one level and float the other
`timescale 1ns/10ps
`default_nettype none
module egpio_pad_cell #(
   parameter int PIN = 0
) (
   input wire logic clk,
   input wire logic sys_rst,
   egpio_pad_if.pad pads
);
   wire logic [1:0] code;
   wire logic is_out;
   wire logic lvl;
   wire logic oe_d;
   wire logic out_d;
   wire logic pu_d;
   wire logic pd_d;
   logic oe_q;
   logic out_q;
   logic pu_q;
   logic pd_q;

   assign code = {pads.code_hi[PIN], pads.code_lo[PIN]};
   assign is_out = (pads.dir[PIN] == egpio_pkg::DIR_OUTPUT);
   assign lvl = pads.level[PIN];

   // open drain: p-channel only sources high, n-channel only sinks low
   assign oe_d = is_out &&
                 ((code == egpio_pkg::DRV_PUSH_PULL) ||
                  ((code == egpio_pkg::DRV_PCH_OPEN) && (lvl == egpio_pkg::LEVEL_HIGH)) ||
                  ((code == egpio_pkg::DRV_NCH_OPEN) && (lvl == egpio_pkg::LEVEL_LOW)));
   // high only while driven, so an n-channel pin never shows a level it cannot source
   assign out_d = oe_d && lvl;
   assign pu_d = !is_out && (code == egpio_pkg::IN_PULL_UP);
   assign pd_d = !is_out && (code == egpio_pkg::IN_PULL_DOWN);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oe_q <= 1'b0;
         out_q <= 1'b0;
         pu_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
         out_q <= out_d;
         pu_q <= pu_d;
         pd_q <= pd_d;
      end
   end

   assign pads.pad_oe[PIN] = oe_q;
   assign pads.pad_out[PIN] = out_q;
   assign pads.pull_up[PIN] = pu_q;
   assign pads.pull_down[PIN] = pd_q;
endmodule
`default_nettype wire

// >>> test/egpio_port_sva.sv
// Purpose: port-level checks of the gpio port
// Assumes: one clock, synchronous reset
// Notes: bound onto egpio_port
`timescale 1ns/10ps
`default_nettype none
module egpio_port_sva #(
   parameter int PINS = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_word,
   input wire logic [15:0] bus_rdata,
   input wire logic [PINS-1:0] pad_in,
   input wire logic [PINS-1:0] pad_out,
   input wire logic [PINS-1:0] pad_oe,
   input wire logic [PINS-1:0] pad_pull_up,
   input wire logic [PINS-1:0] pad_pull_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
      else $error("read data outside a read cycle");
   reset_float_a: assert property ($fell(sys_rst) |->
      (pad_oe | pad_pull_up | pad_pull_down) == '0)
      else $error("pads not floating after reset");
   pull_excl_a: assert property ((pad_pull_up & pad_pull_down) == '0)
      else $error("both pulls on one pin");
   drive_no_pull_a: assert property ((pad_oe & (pad_pull_up | pad_pull_down)) == '0)
      else $error("pull enabled on a driven pin");
   high_needs_oe_a: assert property ((pad_out & ~pad_oe) == '0)
      else $error("high level on an undriven pin");
   dir_readback_a: assert property (bus_wr && !bus_word && bus_addr == 16'hF253
      ##1 !bus_wr ##1 bus_rd && bus_addr == 16'hF253
      |=> bus_rdata == ($past(bus_wdata, 3) & 16'h00FF))
      else $error("direction read back differs");
   word_readback_a: assert property (bus_wr && bus_word && bus_addr == 16'hF254
      ##1 !bus_wr ##1 bus_rd && bus_word && bus_addr == 16'hF254
      |=> bus_rdata == $past(bus_wdata, 3))
      else $error("drive select word read back differs");
   input_float_a: assert property (bus_wr && !bus_word && bus_addr == 16'hF253
      && bus_wdata[7:0] == 8'hFF ##1 !bus_wr |=> pad_oe == '0)
      else $error("input pin still driven");
   pads_hold_a: assert property (!$past(bus_wr) && !$past(bus_wr, 2) |->
      $stable(pad_oe) && $stable(pad_out) && $stable(pad_pull_up) && $stable(pad_pull_down))
      else $error("pad controls moved without a write");
endmodule
bind egpio_port egpio_port_sva #(.PINS(PINS)) egpio_port_sva_inst (.clk(clk), .sys_rst(sys_rst),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_word(bus_word), .bus_rdata(bus_rdata), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down));
`default_nettype wire

// >>> test/egpio_pins_model.sv
// Purpose: board side of the eight port pins
// Assumes: bench chooses which pins it drives
// Notes: a floating pin shows the inverse of the board level
`timescale 1ns/10ps
`default_nettype none
module egpio_pins_model (
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pull_up,
   input wire logic [7:0] pad_pull_down,
   input wire logic [7:0] ext_level,
   input wire logic [7:0] ext_en,
   output logic [7:0] pad_in
);
   // a driven pad wins over the board; an undriven, unpulled pin never keeps a level
   always_comb for (int i = 0; i < 8; i++) pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ?
      ext_level[i] : pad_pull_up[i] ? 1'b1 : pad_pull_down[i] ? 1'b0 : ~ext_level[i];
endmodule
`default_nettype wire

// >>> test/egpio_port_tb_top.sv
// Purpose: random and corner tests of the gpio port
// Assumes: pins model on the far side
// Notes: expected pad states come from pads_exp
`timescale 1ns/10ps
`default_nettype none
module egpio_port_tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata;
   logic bus_wr = 1'b0, bus_rd = 1'b0, bus_word = 1'b0;
   logic [7:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
   logic [7:0] ext_level = 8'h00, ext_en = 8'h00;
   logic [7:0] d, lo, hi, lv, pin;
   logic [31:0] e;
   logic [31:0] pads_now;
   assign pads_now = {pad_oe, pad_out, pad_pull_up, pad_pull_down};
   int fail_count = 0, samples_checked = 0, cycles = 0;
   egpio_port egpio_port_inst (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word),
      .bus_rdata(bus_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down));
   egpio_pins_model egpio_pins_model_inst (.pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_level(ext_level),
      .ext_en(ext_en), .pad_in(pad_in));
   initial forever #10 clk = ~clk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic w);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_word <= w;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic w, input logic [31:0] x);
      @(posedge clk);
      bus_addr <= a;
      bus_word <= w;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 chk({16'h0000, bus_rdata}, x);
   endtask
   // packs {oe, out, pull_up, pull_down}, eight bits each
   function automatic logic [31:0] pads_exp(input logic [7:0] d, lo, hi, lv);
      logic [3:0] p;
      pads_exp = 32'h0;
      for (int i = 0; i < 8; i++) begin
         case ({d[i], hi[i], lo[i]})
            3'h1: p = {lv[i], lv[i], 2'h0};
            3'h2: p = {~lv[i], 3'h0};
            3'h3: p = {1'b1, lv[i], 2'h0};
            3'h5: p = 4'h1;
            3'h6: p = 4'h2;
            default: p = 4'h0;
         endcase
         {pads_exp[24+i], pads_exp[16+i], pads_exp[8+i], pads_exp[i]} = p;
      end
   endfunction
   initial begin
      e = $urandom(32'h3547);
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         rdc(16'hF252 + 16'(a), 1'b0, 32'h0);
      end
      $display("reset values done");
      // first eight passes sweep every code in both modes on all pins
      for (int n = 0; n < 40; n++) begin
         d = n < 8 ? {8{n[2]}} : 8'($urandom);
         hi = n < 8 ? {8{n[1]}} : 8'($urandom);
         lo = n < 8 ? {8{n[0]}} : 8'($urandom);
         lv = 8'($urandom);
         ext_level <= 8'($urandom);
         ext_en <= 8'($urandom);
         wr(16'hF252, {8'h00, lv}, 1'b0);
         wr(16'hF253, {8'h00, d}, 1'b0);
         rdc(16'hF253, 1'b0, {24'h0, d});
         wr(16'hF254, {hi, lo}, 1'b1);
         rdc(16'hF254, 1'b1, {16'h0, hi, lo});
         repeat (3) @(posedge clk);
         e = pads_exp(d, lo, hi, lv);
         #1 chk(pads_now, e);
         pin = (ext_en & ext_level) | (~ext_en & (e[15:8] | (~e[7:0] & ~ext_level)));
         pin = (d & pin) | (~d & lv);
         rdc(16'hF252, 1'b0, {24'h0, pin});
         rdc(16'hF25A, 1'b0, {24'h0, e[31:24]});
         rdc(16'hF25B, 1'b0, {24'h0, e[15:8]});
         rdc(16'hF25C, 1'b0, {24'h0, e[7:0]});
      end
      $display("pad mode sweep done");
      wr(16'hF254, 16'hFFFF, 1'b1);
      wr(16'hF253, 16'h00FF, 1'b0);
      wr(16'hF252, 16'h005A, 1'b0);
      wr(16'hF253, 16'h0000, 1'b0);
      repeat (2) @(posedge clk);
      #1 chk({24'h0, pad_out}, 32'h5A);
      wr(16'hF255, 16'h003C, 1'b0);
      rdc(16'hF254, 1'b1, 32'h3CFF);
      rdc(16'hF255, 1'b0, 32'h3C);
      wr(16'hF260, 16'hFFFF, 1'b1);
      rdc(16'hF260, 1'b1, 32'h0);
      // a pin change must take two stages before a read can see it
      ext_en <= 8'hFF;
      ext_level <= 8'h00;
      wr(16'hF253, 16'h00FF, 1'b0);
      repeat (3) @(posedge clk);
      ext_level <= 8'hA5;
      rdc(16'hF252, 1'b0, 32'h00);
      rdc(16'hF252, 1'b0, 32'hA5);
      $display("corner cases done");
      give_verdict();
   end
endmodule
`default_nettype wire
